// ==== rtl/acssc_pkg.sv ====
// shared constants and types of the conversion start and status control block
package acssc_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS  = 20;   // system clock, 50 MHz
  localparam int CONVCLK_NS     = 80;   // conversion clock period
  localparam int CONV_TIME_NS   = 1360; // one pair conversion
  localparam int CONVCLK_CYCLES = (CONVCLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_PAIRS      = 3;
  // ==========================================================
  // register map
  localparam logic [7:0]  ADDR_CONTROL  = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [31:0] CONTROL_RESET = 32'h00000000;
  localparam int          POLARITY_BIT  = 20; // status polarity bit
  localparam int          FUNCTION_BIT  = 21; // status pin function bit
  localparam int          PAIRWISE_BIT  = 23; // sequential select bit
  localparam int          ST_DOWN_LSB   = 0;  // partial power-down, 3 bits
  localparam int          ST_FLIGHT_LSB = 3;  // pairs converting, 3 bits
  localparam int          ST_BUSY_BIT   = 6;
  localparam int          ST_INT_BIT    = 7;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // ==========================================================
  // pair converter states
  typedef enum logic [1:0] {
    PAIR_IDLE = 2'b00,
    PAIR_CONV = 2'b01,
    PAIR_DONE = 2'b10,
    PAIR_DOWN = 2'b11
  } acssc_pair_state_type;
endpackage : acssc_pkg

// ==== rtl/acssc_edge_det.sv ====
// rising and falling edge detector for a group of synchronous inputs
`timescale 1ns/1ns
module acssc_edge_det #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] sig,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] prev_ff; // value one clock ago

  // ==========================================================
  // history
  // reset value all ones: a high pin at reset is not seen as a rise, a low one is seen as a fall
  always_ff @(posedge clk)
  begin
    if (reset)
      prev_ff <= '1;
    else
      prev_ff <= sig;
  end

  assign rise = sig & ~prev_ff;
  assign fall = ~sig & prev_ff;
endmodule : acssc_edge_det

// ==== rtl/acssc_pair_conv.sv ====
// sequencer of one converter pair: conversion time, completion, power-down
`timescale 1ns/1ns
module acssc_pair_conv (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic launch,     // start a conversion
  input  wire logic abort,      // start input fell while converting
  output logic      converting,
  output logic      donePulse,  // one cycle, results latched
  output logic      powerDown   // pair in partial power-down
);
  acssc_pkg::acssc_pair_state_type state_ff;
  logic [7:0] count_ff; // cycles left in conversion
  logic       down_ff;  // registered power-down, feeds a top-level output

  // ==========================================================
  // state machine; a new launch leaves power-down
  always_ff @(posedge clk)
  begin
    if (reset)
      state_ff <= acssc_pkg::PAIR_IDLE;
    else
      case (state_ff)
        acssc_pkg::PAIR_CONV:
          if (abort)
            state_ff <= acssc_pkg::PAIR_DOWN;
          else if (count_ff == 8'h01)
            state_ff <= acssc_pkg::PAIR_DONE;
        acssc_pkg::PAIR_IDLE, acssc_pkg::PAIR_DONE, acssc_pkg::PAIR_DOWN:
          if (launch)
            state_ff <= acssc_pkg::PAIR_CONV;
          else if (state_ff == acssc_pkg::PAIR_DONE)
            state_ff <= acssc_pkg::PAIR_IDLE;
        default:
          state_ff <= acssc_pkg::PAIR_IDLE;
      endcase
  end

  // ==========================================================
  // conversion timer
  always_ff @(posedge clk)
  begin
    if (reset)
      count_ff <= 8'h00;
    else if (launch && state_ff != acssc_pkg::PAIR_CONV)
      count_ff <= 8'(acssc_pkg::CONV_CYCLES);
    else if (count_ff != 8'h00)
      count_ff <= count_ff - 8'h01;
  end

  // ==========================================================
  // power-down flag; mirrors entry to and exit from the down state
  // kept as its own flip-flop so the pin carries no decode glitches
  always_ff @(posedge clk)
  begin
    if (reset)
      down_ff <= 1'b0;
    else if (state_ff == acssc_pkg::PAIR_CONV)
      down_ff <= abort;
    else if (launch)
      down_ff <= 1'b0;
  end

  assign converting = (state_ff == acssc_pkg::PAIR_CONV);
  assign donePulse  = (state_ff == acssc_pkg::PAIR_DONE);
  assign powerDown  = down_ff;
endmodule : acssc_pair_conv

// ==== rtl/acssc_ctrl.sv ====
// conversion start, status pin and host strobe control of a six-channel converter
//
// Operation
// - status function zero: busy high during conversion
// - busy drops when all launched pairs are done or down; sequential after pair C
// - sequential: one conversion clock low per pair
// - status function one: interrupt until result read
// - polarity bit inverts the status pin
// - parallel: select low enables, high disables
// - serial: frame falling edge starts the transfer
// - parallel outputs driven only while read low
// - hardware mode: start rising edge launches pair
// - hardware: start falling early powers the pair down
// - software mode: pair A starts all or A
// - software: B and C act only sequentially
// - standby low powers down all but the register interface
// - interface select zero parallel, one serial
`timescale 1ns/1ns
module acssc_ctrl (
  input  wire logic        clk,
  input  wire logic        reset,
  // device pins
  input  wire logic        pairAStart,
  input  wire logic        pairBStart,
  input  wire logic        pairCStart,
  input  wire logic        selectFrameN,     // chip select or frame sync
  input  wire logic        readN,            // parallel read strobe
  input  wire logic        standbyN,         // low: standby
  input  wire logic        configModeSw,     // 0 pin, 1 register configured
  input  wire logic        interfaceSerial,  // 0 parallel, 1 serial
  output logic             statusPin_ff,     // busy or interrupt
  output logic             parOutEnable_ff,  // parallel data driver enable
  output logic             parIfEnable_ff,   // parallel interface enabled
  output logic             frameStart_ff,    // serial frame begins
  output logic [2:0]       pairPowerDown,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ==========================================================
  // declarations
  logic [31:0] control_ff;      // control register
  logic [7:0]  awAddr_ff;       // held write address
  logic        awHeld_ff;
  logic [31:0] wData_ff;        // held write data
  logic [3:0]  wStrb_ff;
  logic        wHeld_ff;
  logic [4:0]  rise;            // edges of start, read and frame pins
  logic [4:0]  fall;
  logic [2:0]  startLevel;
  logic [2:0]  launch;
  logic [2:0]  converting;
  logic [2:0]  donePulse;
  logic [2:0]  inFlight_ff;     // pairs launched, not yet finished
  logic        busyLevel_ff;    // busy before low pulses
  logic [3:0]  lowCnt_ff;       // sequential low pulse timer
  logic        intPending_ff;   // interrupt waiting for a read
  logic        hwMode;
  logic        seqMode;
  logic        statusFunc;
  logic        polarity;
  logic        pairEvt;         // some pair finished or went down
  logic        completeEvt;     // whole conversion finished
  logic        readEvt;         // host read the result
  logic        nxt_busyLevel;
  logic        nxt_status;
  logic        powered;
  logic        blockReset;      // reset or standby

  assign hwMode     = ~configModeSw;
  assign seqMode    = configModeSw & control_ff[acssc_pkg::PAIRWISE_BIT];
  assign statusFunc = control_ff[acssc_pkg::FUNCTION_BIT];
  assign polarity   = control_ff[acssc_pkg::POLARITY_BIT];
  assign powered    = standbyN;
  assign blockReset = reset | ~standbyN;
  assign startLevel = {pairCStart, pairBStart, pairAStart};

  // ==========================================================
  // edge detection of the host strobes
  acssc_edge_det #(
    .WIDTH(5)
  ) u_edges (
    .clk  (clk),
    .reset(blockReset),
    .sig  ({selectFrameN, readN, startLevel}),
    .rise (rise),
    .fall (fall)
  );

  // ==========================================================
  // launch decode
  always_comb
  begin
    if (hwMode)
      launch = rise[2:0];
    else if (seqMode)
      launch = rise[2:0];
    else
      launch = {3{rise[0]}};
    // a pair already converting ignores another start
    launch = launch & ~converting;
  end

  // ==========================================================
  // three pair sequencers
  genvar gi;
  generate
    for (gi = 0; gi < acssc_pkg::NUM_PAIRS; gi++)
    begin : g_pair
      acssc_pair_conv u_pair (
        .clk       (clk),
        .reset     (blockReset),
        .launch    (launch[gi]),
        .abort     (hwMode & ~startLevel[gi]),
        .converting(converting[gi]),
        .donePulse (donePulse[gi]),
        .powerDown (pairPowerDown[gi])
      );
    end
  endgenerate

  // ==========================================================
  // conversion tracking
  assign pairEvt = |(inFlight_ff & (donePulse | pairPowerDown));
  // sequential: the run ends with pair C; otherwise when nothing is left
  assign completeEvt = seqMode ? (inFlight_ff[2] & donePulse[2])
                               : (pairEvt && (inFlight_ff & ~donePulse
                                              & ~pairPowerDown) == 3'b000);

  // pairs in flight, cleared by completion or power-down
  always_ff @(posedge clk)
  begin
    if (blockReset)
      inFlight_ff <= 3'b000;
    else
      inFlight_ff <= (inFlight_ff & ~donePulse & ~pairPowerDown) | launch;
  end

  // busy level: set by launch, dropped when all launched pairs are done or down, or when pair C is done in sequential mode
  always_comb
  begin
    nxt_busyLevel = busyLevel_ff;
    if (completeEvt)
      nxt_busyLevel = 1'b0;
    if (|launch)
      nxt_busyLevel = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (blockReset)
      busyLevel_ff <= 1'b0;
    else
      busyLevel_ff <= nxt_busyLevel;
  end

  // sequential mode: one conversion clock low per finished pair
  always_ff @(posedge clk)
  begin
    if (blockReset)
      lowCnt_ff <= 4'h0;
    else if (seqMode && |(donePulse & inFlight_ff))
      lowCnt_ff <= 4'(acssc_pkg::CONVCLK_CYCLES);
    else if (lowCnt_ff != 4'h0)
      lowCnt_ff <= lowCnt_ff - 4'h1;
  end

  // ==========================================================
  // interrupt: read by strobe in parallel, frame edge in serial
  assign readEvt = interfaceSerial ? fall[4] : (fall[3] & ~selectFrameN);

  // a completion in the same cycle as a read wins
  always_ff @(posedge clk)
  begin
    if (blockReset)
      intPending_ff <= 1'b0;
    else if (completeEvt)
      intPending_ff <= 1'b1;
    else if (readEvt)
      intPending_ff <= 1'b0;
  end

  // ==========================================================
  // status pin
  always_comb
  begin
    if (statusFunc)
      nxt_status = intPending_ff;
    else
      nxt_status = busyLevel_ff & (lowCnt_ff == 4'h0);
    nxt_status = nxt_status ^ polarity;
  end

  // standby parks the pin at its inactive level
  always_ff @(posedge clk)
  begin
    if (reset)
      statusPin_ff <= 1'b0;
    else
      statusPin_ff <= nxt_status;
  end

  // ==========================================================
  // host interface strobes
  // parallel interface open only while select is low
  always_ff @(posedge clk)
  begin
    if (reset)
      parIfEnable_ff <= 1'b0;
    else
      parIfEnable_ff <= powered & ~interfaceSerial & ~selectFrameN;
  end

  // data drivers follow the read strobe; one cycle late
  always_ff @(posedge clk)
  begin
    if (reset)
      parOutEnable_ff <= 1'b0;
    else
      parOutEnable_ff <= powered & ~interfaceSerial & ~selectFrameN & ~readN;
  end

  // serial frame begins on the falling frame edge
  always_ff @(posedge clk)
  begin
    if (reset)
      frameStart_ff <= 1'b0;
    else
      frameStart_ff <= powered & interfaceSerial & fall[4];
  end

  // ==========================================================
  // AXI4-Lite write: address and data taken in either order
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      awHeld_ff     <= 1'b0;
      awAddr_ff     <= 8'h00;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~awHeld_ff & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      else if (awHeld_ff && wHeld_ff)
        awHeld_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wHeld_ff     <= 1'b0;
      wData_ff     <= 32'h00000000;
      wStrb_ff     <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= s_axi_wvalid & ~s_axi_wready & ~wHeld_ff & ~s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      else if (awHeld_ff && wHeld_ff)
        wHeld_ff <= 1'b0;
    end
  end

  // commit and respond; status is read only, unmapped gets an error
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      control_ff   <= acssc_pkg::CONTROL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= acssc_pkg::RESP_OKAY;
    end
    else if (awHeld_ff && wHeld_ff)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= acssc_pkg::RESP_OKAY;
      if (awAddr_ff[7:2] == acssc_pkg::ADDR_CONTROL[7:2])
      begin
        for (int b = 0; b < 4; b++)
          if (wStrb_ff[b])
            control_ff[8*b +: 8] <= wData_ff[8*b +: 8];
      end
      else if (awAddr_ff[7:2] != acssc_pkg::ADDR_STATUS[7:2])
        s_axi_bresp <= acssc_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ==========================================================
  // AXI4-Lite read
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= acssc_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= acssc_pkg::RESP_OKAY;
        s_axi_rdata  <= 32'h00000000;
        if (s_axi_araddr[7:2] == acssc_pkg::ADDR_CONTROL[7:2])
          s_axi_rdata <= control_ff;
        else if (s_axi_araddr[7:2] == acssc_pkg::ADDR_STATUS[7:2])
        begin
          s_axi_rdata[acssc_pkg::ST_DOWN_LSB +: 3]   <= pairPowerDown;
          s_axi_rdata[acssc_pkg::ST_FLIGHT_LSB +: 3] <= inFlight_ff;
          s_axi_rdata[acssc_pkg::ST_BUSY_BIT]        <= busyLevel_ff;
          s_axi_rdata[acssc_pkg::ST_INT_BIT]         <= intPending_ff;
        end
        else
          s_axi_rresp <= acssc_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // assertions
  logic busyOut; // status pin with polarity removed
  assign busyOut = statusPin_ff ^ polarity;

  property p_busy_start;
    @(posedge clk) disable iff (reset)
    (!statusFunc && !seqMode && |launch && standbyN) ##1 (standbyN && !completeEvt
      && $stable(control_ff)) |=> busyOut;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not raised");

  property p_busy_drop;
    @(posedge clk) disable iff (reset)
    (!statusFunc && !seqMode && completeEvt && launch == 3'b000)
      ##1 ($stable(control_ff) && launch == 3'b000) |=> !busyOut;
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("busy not dropped");

  property p_seq_pulse;
    @(posedge clk) disable iff (blockReset)
    (seqMode && !statusFunc && |(donePulse & inFlight_ff)) ##1 $stable(control_ff)
      |=> !busyOut[*4];
  endproperty
  a_seq_pulse: assert property (p_seq_pulse) else $error("sequential pulse wrong");

  property p_int_hold;
    @(posedge clk) disable iff (blockReset)
    (statusFunc && intPending_ff && !readEvt) ##1 $stable(control_ff) |=> statusPin_ff
      == !polarity;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt lost");

  property p_polarity;
    @(posedge clk) disable iff (reset)
    (!statusFunc && !busyLevel_ff && lowCnt_ff == 4'h0 && polarity) |=> statusPin_ff;
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity ignored");

  property p_par_select;
    @(posedge clk) disable iff (reset)
    (!interfaceSerial && standbyN) |=> parIfEnable_ff == !$past(selectFrameN);
  endproperty
  a_par_select: assert property (p_par_select) else $error("select gating wrong");

  property p_frame;
    @(posedge clk) disable iff (blockReset)
    (interfaceSerial && fall[4]) |=> frameStart_ff;
  endproperty
  a_frame: assert property (p_frame) else $error("frame start missed");

  property p_read_drive;
    @(posedge clk) disable iff (reset)
    readN |=> !parOutEnable_ff;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("driving while read high");

  property p_hw_launch;
    @(posedge clk) disable iff (blockReset)
    (hwMode && rise[1] && !converting[1]) |=> converting[1];
  endproperty
  a_hw_launch: assert property (p_hw_launch) else $error("pair B not launched");

  property p_abort;
    @(posedge clk) disable iff (blockReset)
    (hwMode && converting[1] && !pairBStart) |=> pairPowerDown[1];
  endproperty
  a_abort: assert property (p_abort) else $error("no partial power-down");

  property p_sw_all;
    @(posedge clk) disable iff (blockReset)
    (!hwMode && !seqMode && rise[0] && converting == 3'b000) |=> converting == 3'b111;
  endproperty
  a_sw_all: assert property (p_sw_all) else $error("not all pairs started");

  property p_sw_b_ignored;
    @(posedge clk) disable iff (blockReset)
    (!hwMode && !seqMode && rise[1] && !rise[0] && !converting[1]) |=> !converting[1];
  endproperty
  a_sw_b_ignored: assert property (p_sw_b_ignored) else $error("pair B started");

  property p_standby;
    @(posedge clk) disable iff (reset)
    !standbyN |=> (converting == 3'b000 && !busyLevel_ff && !intPending_ff);
  endproperty
  a_standby: assert property (p_standby) else $error("active in standby");

  c_hw_conv: cover property (@(posedge clk) hwMode && |donePulse);
  c_seq_pulse: cover property (@(posedge clk) seqMode && lowCnt_ff == 4'h1);
  c_int_read: cover property (@(posedge clk) intPending_ff && readEvt);
endmodule : acssc_ctrl

// ==== tb/acssc_host_model.sv ====
// host side model: pair start inputs, select or frame pin, read strobe
`timescale 1ns/1ns
module acssc_host_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [2:0] go,          // pairs to launch, one cycle
  input  wire logic [7:0] holdCyc,     // one less than the cycles a start stays high
  input  wire logic       readGo,      // one read event, one cycle
  input  wire logic       serialMode,  // follows the interface select
  output logic      [2:0] startPin,    // bit0 pair a
  output wire logic       selectFrameN,
  output wire logic       readN
);
  // ==========================================================
  // start inputs
  logic [7:0] hold_ff;    // remaining high time
  logic [2:0] rdStep_ff;  // read event sequencer
  // a short holdCyc drops a start before its conversion ends, on purpose
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      startPin <= 3'h0;
      hold_ff  <= 8'h00;
    end
    else if (go != 3'h0)
    begin
      startPin <= go;
      hold_ff  <= holdCyc;
    end
    else if (hold_ff != 8'h00)
      hold_ff <= hold_ff - 8'h01;
    else
      startPin <= 3'h0;
  end
  // ==========================================================
  // read event: select falls first, strobe low inside it
  always_ff @(posedge clk)
  begin
    if (reset)
      rdStep_ff <= 3'h0;
    else if (readGo)
      rdStep_ff <= 3'h5;
    else if (rdStep_ff != 3'h0)
      rdStep_ff <= rdStep_ff - 3'h1;
  end
  assign selectFrameN = (rdStep_ff == 3'h0);
  // serial mode ties the strobe low, it is unused there
  assign readN = serialMode ? 1'h0 : !(rdStep_ff inside {3'h2, 3'h3});
endmodule : acssc_host_model

// ==== tb/adc_conversion_start_status_control_bench.sv ====
// self-checking bench of the conversion start and status control block
`timescale 1ns/1ns
module adc_conversion_start_status_control_bench;
  // ==========================================================
  // signals
  logic        clk = 1'h0;
  logic        reset = 1'h1;
  wire         pairAStart, pairBStart, pairCStart, selectFrameN, readN;
  logic        standbyN = 1'h1;
  logic        configModeSw = 1'h0;
  logic        interfaceSerial = 1'h0;
  logic        statusPin_ff, parOutEnable_ff, parIfEnable_ff, frameStart_ff;
  logic [2:0]  pairPowerDown;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd, v;
  logic [31:0] lfsr = 32'hA49EC515;
  logic [2:0]  go = 3'h0;
  logic [7:0]  holdCyc = 8'h00;
  logic        readGo = 1'h0;
  logic        seenPe, seenOe, seenFrame;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cnt;
  acssc_ctrl uut (
    .clk, .reset, .pairAStart, .pairBStart, .pairCStart, .selectFrameN, .readN,
    .standbyN, .configModeSw, .interfaceSerial, .statusPin_ff, .parOutEnable_ff,
    .parIfEnable_ff, .frameStart_ff, .pairPowerDown, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  acssc_host_model host (
    .clk, .reset, .go, .holdCyc, .readGo, .serialMode(interfaceSerial),
    .startPin({pairCStart, pairBStart, pairAStart}), .selectFrameN, .readN
  );
  always #10 clk = ~clk;
  // ==========================================================
  // helpers
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRand
  // busy spans the conversion plus the completion cycle
  function automatic int busyLen();
    return acssc_pkg::CONV_CYCLES + 1;
  endfunction : busyLen
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic results();
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic axiW(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready === 1'h1)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1)
        s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge clk);
  endtask : axiW
  task automatic axiR(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready === 1'h1)
        s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask : axiR
  task automatic fire(input logic [2:0] p, input logic [7:0] h);
    go <= p;
    holdCyc <= h;
    @(posedge clk);
    go <= 3'h0;
  endtask : fire
  // counts cycles of the status pin at one level over a fixed window
  task automatic busyCount(input logic act);
    cnt = 0;
    repeat (100)
    begin
      @(posedge clk);
      if (statusPin_ff === act)
        cnt++;
    end
  endtask : busyCount
  task automatic readEvt();
    readGo <= 1'h1;
    seenPe = 1'h0;
    seenOe = 1'h0;
    seenFrame = 1'h0;
    repeat (10)
    begin
      @(posedge clk);
      readGo <= 1'h0;
      seenPe |= parIfEnable_ff;
      seenOe |= parOutEnable_ff;
      seenFrame |= frameStart_ff;
    end
  endtask : readEvt
  // ==========================================================
  // watchdog, far beyond the fewer than one thousand cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    axiR(acssc_pkg::ADDR_CONTROL);
    chk(rd, acssc_pkg::CONTROL_RESET);
    chk(statusPin_ff, 1'h0);
    axiR(8'h08);
    chk(rsp, acssc_pkg::RESP_SLVERR);
    axiW(8'h0C, lfsr);
    chk(rsp, acssc_pkg::RESP_SLVERR);
    repeat (4)
    begin
      lfsr = nextRand(lfsr);
      v = lfsr & 32'hFF4FFFFF;
      axiW(acssc_pkg::ADDR_CONTROL, v);
      axiR(acssc_pkg::ADDR_CONTROL);
      chk(rd, v);
    end
    axiW(acssc_pkg::ADDR_CONTROL, 32'h00000000);
    fire(3'h7, 8'h5A);
    busyCount(1'h1);
    chk(cnt, busyLen());
    axiW(acssc_pkg::ADDR_CONTROL, 32'h00100000);
    chk(statusPin_ff, 1'h1);
    fire(3'h1, 8'h5A);
    busyCount(1'h0);
    chk(cnt, busyLen());
    axiW(acssc_pkg::ADDR_CONTROL, 32'h00200000);
    fire(3'h2, 8'h5A);
    busyCount(1'h1);
    chk(statusPin_ff, 1'h1);
    interfaceSerial <= 1'h1;
    readEvt();
    chk({seenFrame, seenPe}, 2'h2);
    chk(statusPin_ff, 1'h0);
    interfaceSerial <= 1'h0;
    fire(3'h4, 8'h5A);
    busyCount(1'h1);
    readEvt();
    chk({seenPe, seenOe, seenFrame}, 3'h6);
    chk({statusPin_ff, parIfEnable_ff, parOutEnable_ff}, 3'h0);
    axiW(acssc_pkg::ADDR_CONTROL, 32'h00000000);
    fire(3'h2, 8'h0A);
    repeat (20) @(posedge clk);
    chk(pairPowerDown, 3'h2);
    repeat (80) @(posedge clk);
    configModeSw <= 1'h1;
    fire(3'h2, 8'h5A);
    repeat (3) @(posedge clk);
    axiR(acssc_pkg::ADDR_STATUS);
    chk(rd[acssc_pkg::ST_FLIGHT_LSB +: 3], 3'h0);
    repeat (100) @(posedge clk);
    fire(3'h1, 8'h5A);
    repeat (3) @(posedge clk);
    axiR(acssc_pkg::ADDR_STATUS);
    chk(rd[acssc_pkg::ST_FLIGHT_LSB +: 3], 3'h7);
    repeat (100) @(posedge clk);
    axiW(acssc_pkg::ADDR_CONTROL, 32'h00800000);
    fire(3'h1, 8'h5A);
    repeat (3) @(posedge clk);
    axiR(acssc_pkg::ADDR_STATUS);
    chk(rd[acssc_pkg::ST_FLIGHT_LSB +: 3], 3'h1);
    busyCount(1'h0);
    chk(cnt, acssc_pkg::CONVCLK_CYCLES);
    standbyN <= 1'h0;
    repeat (3) @(posedge clk);
    chk({statusPin_ff, pairPowerDown}, 4'h0);
    standbyN <= 1'h1;
    axiR(acssc_pkg::ADDR_STATUS);
    chk(rd[5:0], 6'h00);
    results();
  end
endmodule : adc_conversion_start_status_control_bench
